// *** sfc_pkg.sv ***
// Package for the SPI FIFO controller: register map, fields and bus carriers.
// =====================================================================
package sfc_pkg;
  // =====================================================================
  // Register byte addresses.
  localparam logic [31:0] SFC_STAT_ADR = 32'h4002C000;
  localparam logic [31:0] SFC_RXB_ADR = 32'h4002C004;
  localparam logic [31:0] SFC_TXB_ADR = 32'h4002C008;
  localparam logic [31:0] SFC_RATE_ADR = 32'h4002C00C;
  localparam logic [31:0] SFC_SETUP_ADR = 32'h4002C010;
  localparam logic [31:0] SFC_DMA_ADR = 32'h4002C014;
  // Reset values.
  localparam logic [15:0] SFC_SETUP_RST = 16'h0000;
  localparam logic [8:0] SFC_RATE_RST = 9'h000;
  localparam logic [2:0] SFC_DMA_RST = 3'h0;
  // =====================================================================
  // Setup register fields.
  localparam int SFC_S_EN = 0;
  localparam int SFC_S_MST = 1;
  localparam int SFC_S_CPHA = 2;
  localparam int SFC_S_CPOL = 3;
  localparam int SFC_S_LSB = 5;
  localparam int SFC_S_TRIG = 6;
  localparam int SFC_S_ZERO = 7;
  localparam int SFC_S_LOOP = 10;
  localparam int SFC_S_STRM = 11;
  localparam int SFC_S_RPRG = 12;
  localparam int SFC_S_TPRG = 13;
  localparam int SFC_S_THR = 14;
  // Rate register fields.
  localparam int SFC_R_HFM = 6;
  localparam int SFC_R_BCC = 7;
  localparam int SFC_R_CSIRQ = 8;
  // Status register fields.
  localparam int SFC_T_IRQ = 0;
  localparam int SFC_T_TXCNT = 1;
  localparam int SFC_T_TXUR = 4;
  localparam int SFC_T_TXF = 5;
  localparam int SFC_T_RXF = 6;
  localparam int SFC_T_RXOF = 7;
  localparam int SFC_T_RXCNT = 8;
  localparam int SFC_T_ABORT = 12;
  localparam int SFC_T_FALL = 13;
  localparam int SFC_T_RISE = 14;
  localparam int SFC_T_BUSY = 15;
  // =====================================================================
  // Bus carriers.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sfc_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sfc_wb_rsp_t;
endpackage

// *** sfc_top.sv ***
// SPI FIFO controller: Wishbone slave, FIFOs, master and slave serial engine.
`timescale 1ns/1ps
`default_nettype none
module sfc_top #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sfc_pkg::sfc_wb_req_t wb_i,
  output var sfc_pkg::sfc_wb_rsp_t wb_o,
  output logic irq_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic returned_serial_clock_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o
);
  import sfc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // The threshold field reaches four bytes, so the FIFO must hold four.
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two and at least 4.");
  end

  typedef enum logic [1:0] {SFC_IDLE, SFC_LEAD, SFC_TRAIL, SFC_GAP} sfc_state_t;

  // Reverses bit order for LSB-first transfers.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // =====================================================================
  // State declarations.
  logic [15:0] setup_q; // Setup register.
  logic [8:0] rate_q; // Rate register.
  logic [2:0] dma_q; // DMA enable register.
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] txm [DEPTH]; // Transmit storage.
  logic [7:0] rxm [DEPTH]; // Receive storage.
  logic [AW-1:0] twp_q, trp_q, rwp_q, rrp_q;
  logic [CW-1:0] tcnt_q, rcnt_q;
  logic f_txur_q, f_tx_q, f_rx_q, f_rxof_q, f_abort_q, f_fall_q, f_rise_q;
  logic irq_q;
  sfc_state_t st_q;
  logic [5:0] div_q; // Half-period counter.
  logic [2:0] mbit_q; // Master bit counter.
  logic gap_q; // Second half of the stall period.
  logic pend_q; // A software trigger waits for the engine.
  logic sclk_q, cs_q, out_q, oe_n_q;
  logic [7:0] tx_sh_q, rx_sh_q, last_q;
  logic [2:0] rbit_q; // Receive bit counter, shared by both modes.
  logic [1:0] tdone_q; // Bytes sent since the last transmit flag.
  logic sclk_prev_q, cs_prev_q, ret_prev_q, cs_seen_q;

  // =====================================================================
  // Decoded controls.
  logic en, mst, slv, cpha, cpol, lsb, trig, idle_zero_fill, loopb, strm, rprg, tprg;
  logic high_speed_sampling, bcc, csirq, dma;
  logic [1:0] thr;
  assign en = setup_q[SFC_S_EN];
  assign mst = en & setup_q[SFC_S_MST];
  assign slv = en & ~setup_q[SFC_S_MST];
  assign cpha = setup_q[SFC_S_CPHA];
  assign cpol = setup_q[SFC_S_CPOL];
  assign lsb = setup_q[SFC_S_LSB];
  assign trig = setup_q[SFC_S_TRIG];
  assign idle_zero_fill = setup_q[SFC_S_ZERO];
  assign loopb = setup_q[SFC_S_LOOP];
  assign strm = setup_q[SFC_S_STRM];
  assign rprg = setup_q[SFC_S_RPRG];
  assign tprg = setup_q[SFC_S_TPRG];
  assign thr = setup_q[SFC_S_THR +: 2];
  assign high_speed_sampling = rate_q[SFC_R_HFM];
  assign bcc = rate_q[SFC_R_BCC];
  assign csirq = rate_q[SFC_R_CSIRQ];
  assign dma = dma_q[0];

  // =====================================================================
  // Bus decode. Every access is answered one cycle after it is seen.
  logic acc, rd_rx, wr_tx, rd_st;
  assign acc = wb_i.cyc & wb_i.stb & ~ack_q;
  assign rd_rx = acc & ~wb_i.we & (wb_i.adr == SFC_RXB_ADR);
  assign rd_st = acc & ~wb_i.we & (wb_i.adr == SFC_STAT_ADR);
  // Writes are refused while the transmit purge is held.
  assign wr_tx = acc & wb_i.we & (wb_i.adr == SFC_TXB_ADR) & wb_i.sel[0] & ~tprg;

  // Push and pop counts for both FIFOs; a write that does not fit is dropped.
  logic [1:0] tpush_n, rpop_n;
  logic [CW-1:0] tfree;
  assign tfree = CW'(DEPTH) - tcnt_q;
  always_comb begin
    tpush_n = 2'd0;
    if (wr_tx) begin
      // The second byte only counts for half-word DMA access.
      if (dma & wb_i.sel[1]) begin
        tpush_n = (tfree >= CW'(2)) ? 2'd2 : 2'd0;
      end else begin
        tpush_n = (tfree != '0) ? 2'd1 : 2'd0;
      end
    end
    rpop_n = 2'd0;
    if (rd_rx) begin
      if (dma & (rcnt_q >= CW'(2))) begin
        rpop_n = 2'd2;
      end else if (rcnt_q != '0) begin
        rpop_n = 2'd1;
      end
    end
  end

  // =====================================================================
  // Serial engine events.
  logic tick, m_start, lead_t, trail_t, m_done, m_next;
  logic s_edge, s_lead, s_trail, s_fall, s_rise;
  logic load, load_drv, drive, smp, din, rx_done, ret_smp;
  logic [7:0] tx_byte, tx_ord, rx_byte;
  logic tx_have, rx_ok;
  assign tx_have = (tcnt_q != '0);
  // The serial clock half-period is (ratio + 1) core clock cycles.
  assign tick = (div_q == rate_q[5:0]);
  // A pending trigger, or queued data when writes start transfers.
  assign m_start = (st_q == SFC_IDLE) & mst & (pend_q | (trig & tx_have & ~tprg));
  assign lead_t = (st_q == SFC_LEAD) & tick;
  assign trail_t = (st_q == SFC_TRAIL) & tick;
  assign m_done = trail_t & (mbit_q == 3'd7);
  // Streaming continues with the select held while data remains.
  assign m_next = m_done & strm & tx_have & ~tprg;
  assign s_edge = sclk_i != sclk_prev_q;
  assign s_lead = slv & ~cs_n_i & s_edge & (sclk_i != cpol);
  assign s_trail = slv & ~cs_n_i & s_edge & (sclk_i == cpol);
  assign s_fall = slv & cs_prev_q & ~cs_n_i;
  assign s_rise = slv & ~cs_prev_q & cs_n_i;
  assign rx_done = smp & (rbit_q == 3'd7);
  // Slave loads at select fall with the bit count at zero, or after each received byte.
  assign load = m_start | m_next | (s_fall & (rbit_q == 3'd0)) | (slv & ~cs_n_i & rx_done);
  assign load_drv = ~cpha & (m_start | m_next | (s_fall & (rbit_q == 3'd0)));
  assign drive = mst ? ((lead_t & cpha) | (trail_t & ~cpha)) : ((s_lead & cpha) | (s_trail & ~cpha));
  // The returned clock edge on which data is sampled in high-speed mode.
  assign ret_smp = (returned_serial_clock_i != ret_prev_q)
                 & ((returned_serial_clock_i != cpol) == ~cpha);
  assign smp = mst ? (high_speed_sampling ? (ret_smp & ~cs_q) : ((lead_t & ~cpha) | (trail_t & cpha)))
                   : ((s_lead & ~cpha) | (s_trail & cpha));
  // Loopback takes the bit that is being sent.
  assign din = loopb ? out_q : (mst ? miso_i : mosi_i);
  // An empty FIFO, purged or not, sends the last byte or zeros.
  assign tx_byte = tx_have ? txm[trp_q] : (idle_zero_fill ? 8'h00 : last_q);
  // The byte in the order it goes on the wire, first bit in position 7.
  assign tx_ord = lsb ? rev8(tx_byte) : tx_byte;
  assign rx_byte = lsb ? rev8({rx_sh_q[6:0], din}) : {rx_sh_q[6:0], din};
  assign rx_ok = rx_done & ~rprg & (rcnt_q != CW'(DEPTH));

  // =====================================================================
  // Transmit FIFO; the purge holds it empty for as long as it is set.
  always_ff @(posedge clk_i) begin
    if (rst_i || tprg) begin
      twp_q <= '0;
      trp_q <= '0;
      tcnt_q <= '0;
    end else begin
      if (tpush_n != 2'd0) begin
        txm[twp_q] <= wb_i.dat[7:0];
      end
      if (tpush_n == 2'd2) begin
        txm[twp_q + AW'(1)] <= wb_i.dat[15:8];
      end
      twp_q <= twp_q + AW'(tpush_n);
      trp_q <= trp_q + AW'(load & tx_have);
      tcnt_q <= tcnt_q + CW'(tpush_n) - CW'(load & tx_have);
    end
  end

  // =====================================================================
  // Receive FIFO; the purge empties it and drops incoming bytes.
  always_ff @(posedge clk_i) begin
    if (rst_i || rprg) begin
      rwp_q <= '0;
      rrp_q <= '0;
      rcnt_q <= '0;
    end else begin
      if (rx_ok) begin
        rxm[rwp_q] <= rx_byte;
      end
      rwp_q <= rwp_q + AW'(rx_ok);
      rrp_q <= rrp_q + AW'(rpop_n);
      rcnt_q <= rcnt_q + CW'(rx_ok) - CW'(rpop_n);
    end
  end

  // =====================================================================
  // Software registers. Byte lanes are honoured on every write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= SFC_SETUP_RST;
      rate_q <= SFC_RATE_RST;
      dma_q <= SFC_DMA_RST;
    end else if (acc && wb_i.we) begin
      if (wb_i.adr == SFC_SETUP_ADR) begin
        if (wb_i.sel[0]) setup_q[7:0] <= wb_i.dat[7:0];
        if (wb_i.sel[1]) setup_q[15:8] <= wb_i.dat[15:8];
      end else if (wb_i.adr == SFC_RATE_ADR) begin
        if (wb_i.sel[0]) rate_q[7:0] <= wb_i.dat[7:0];
        if (wb_i.sel[1]) rate_q[8] <= wb_i.dat[8];
      end else if (wb_i.adr == SFC_DMA_ADR) begin
        if (wb_i.sel[0]) dma_q <= wb_i.dat[2:0];
      end
    end
  end

  // =====================================================================
  // Bus answer. Unmapped addresses read zero; a write there is ignored.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (wb_i.adr == SFC_STAT_ADR) begin
      rmux[SFC_T_IRQ] = irq_q;
      rmux[SFC_T_TXCNT +: 3] = 3'(tcnt_q);
      rmux[SFC_T_TXUR] = f_txur_q;
      rmux[SFC_T_TXF] = f_tx_q;
      rmux[SFC_T_RXF] = f_rx_q;
      rmux[SFC_T_RXOF] = f_rxof_q;
      rmux[SFC_T_RXCNT +: 3] = 3'(rcnt_q);
      rmux[SFC_T_ABORT] = f_abort_q;
      rmux[SFC_T_FALL] = f_fall_q;
      rmux[SFC_T_RISE] = f_rise_q;
      rmux[SFC_T_BUSY] = (st_q != SFC_IDLE);
    end else if (wb_i.adr == SFC_RXB_ADR) begin
      rmux[7:0] = (rcnt_q != '0) ? rxm[rrp_q] : 8'h00;
      // The upper byte reads zero unless DMA pops two bytes.
      rmux[15:8] = (rpop_n == 2'd2) ? rxm[rrp_q + AW'(1)] : 8'h00;
    end else if (wb_i.adr == SFC_RATE_ADR) begin
      rmux[8:0] = rate_q;
    end else if (wb_i.adr == SFC_SETUP_ADR) begin
      rmux[15:0] = setup_q;
    end else if (wb_i.adr == SFC_DMA_ADR) begin
      rmux[2:0] = dma_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdat_q <= (acc && !wb_i.we) ? rmux : 32'h0000_0000;
    end
  end
  assign wb_o.ack = ack_q;
  assign wb_o.dat = rdat_q;

  // =====================================================================
  // Sticky status flags; a status read clears them but a new event wins.
  logic cs_line, cs_flag_ok, set_rx, set_tx;
  assign cs_line = mst ? cs_q : cs_n_i;
  assign cs_flag_ok = csirq & strm & high_speed_sampling;
  // Receive flag once the FIFO reaches the threshold plus one.
  assign set_rx = ~trig & rx_ok & ((rcnt_q + CW'(1)) >= (CW'(thr) + CW'(1)));
  // Transmit flag when the threshold plus one bytes have been taken for sending.
  assign set_tx = trig & load & (tdone_q == thr);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_txur_q <= 1'b0;
      f_tx_q <= 1'b0;
      f_rx_q <= 1'b0;
      f_rxof_q <= 1'b0;
      f_abort_q <= 1'b0;
      f_fall_q <= 1'b0;
      f_rise_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      f_txur_q <= (load & ~tx_have & ~tprg) | (f_txur_q & ~rd_st);
      f_tx_q <= set_tx | (f_tx_q & ~rd_st);
      f_rx_q <= (set_rx & ~rprg) | (f_rx_q & ~rd_st);
      f_rxof_q <= (rx_done & ~rprg & ~rx_ok) | (f_rxof_q & ~rd_st);
      f_abort_q <= (s_rise & (rbit_q != 3'd0)) | (f_abort_q & ~rd_st);
      f_fall_q <= (cs_flag_ok & cs_seen_q & ~cs_line) | (f_fall_q & ~rd_st);
      f_rise_q <= (cs_flag_ok & ~cs_seen_q & cs_line) | (f_rise_q & ~rd_st);
      irq_q <= f_txur_q | f_tx_q | f_rx_q | f_rxof_q | f_abort_q | f_fall_q | f_rise_q;
    end
  end
  assign irq_o = irq_q;

  // =====================================================================
  // Transfer counter for the transmit flag; counts bytes taken for sending.
  always_ff @(posedge clk_i) begin
    if (rst_i || !trig) begin
      tdone_q <= 2'd0;
    end else if (load) begin
      tdone_q <= (tdone_q == thr) ? 2'd0 : tdone_q + 2'd1;
    end
  end

  // =====================================================================
  // Software trigger: with trig clear, a receive read starts a transfer. Writes start one through
  // the queued data alone, so a write taken mid-stream adds no empty frame.
  always_ff @(posedge clk_i) begin
    if (rst_i || !mst) begin
      pend_q <= 1'b0;
    end else if (rd_rx && !trig) begin
      pend_q <= 1'b1;
    end else if (m_start) begin
      pend_q <= 1'b0;
    end
  end

  // =====================================================================
  // Master sequencer: select, clock halves and the one-clock stall.
  always_ff @(posedge clk_i) begin
    if (rst_i || !mst) begin
      st_q <= SFC_IDLE;
      div_q <= 6'd0;
      mbit_q <= 3'd0;
      gap_q <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= cpol;
    end else begin
      div_q <= (tick || st_q == SFC_IDLE) ? 6'd0 : div_q + 6'd1;
      case (st_q)
        SFC_IDLE: begin
          sclk_q <= cpol;
          if (m_start) begin
            cs_q <= 1'b0;
            mbit_q <= 3'd0;
            st_q <= SFC_LEAD;
          end
        end
        SFC_LEAD: begin
          if (tick) begin
            sclk_q <= ~cpol;
            st_q <= SFC_TRAIL;
          end
        end
        SFC_TRAIL: begin
          if (tick) begin
            sclk_q <= cpol;
            mbit_q <= mbit_q + 3'd1;
            if (m_next) begin
              st_q <= SFC_LEAD;
            end else if (m_done) begin
              // Single-byte mode, or a stream out of data, releases select and stalls one serial clock.
              cs_q <= 1'b1;
              gap_q <= 1'b0;
              st_q <= SFC_GAP;
            end else begin
              st_q <= SFC_LEAD;
            end
          end
        end
        SFC_GAP: begin
          if (tick) begin
            gap_q <= 1'b1;
            if (gap_q) begin
              st_q <= SFC_IDLE;
            end
          end
        end
        default: st_q <= SFC_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Shift data out; the same bit feeds the master and slave data pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh_q <= 8'h00;
      out_q <= 1'b0;
      last_q <= 8'h00;
    end else if (load) begin
      if (tx_have) begin
        last_q <= txm[trp_q];
      end
      if (load_drv) begin
        out_q <= tx_ord[7];
        tx_sh_q <= {tx_ord[6:0], 1'b0};
      end else begin
        tx_sh_q <= tx_ord;
      end
    end else if (drive) begin
      out_q <= tx_sh_q[7];
      tx_sh_q <= tx_sh_q << 1;
    end
  end
  assign mosi_o = out_q;
  assign miso_o = out_q;

  // =====================================================================
  // Shift data in and count received bits; handles select aborts.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      rx_sh_q <= 8'h00;
      rbit_q <= 3'd0;
    end else if (s_rise && bcc) begin
      rbit_q <= 3'd0;
    end else if (smp) begin
      // Without counter clear an abort leaves the count where it stopped.
      rx_sh_q <= {rx_sh_q[6:0], din};
      rbit_q <= rbit_q + 3'd1;
    end
  end

  // =====================================================================
  // Pin history for edge detection and the slave output enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      ret_prev_q <= 1'b0;
      cs_seen_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_i;
      cs_prev_q <= cs_n_i;
      ret_prev_q <= returned_serial_clock_i;
      cs_seen_q <= cs_line;
      oe_n_q <= ~(slv & ~cs_n_i);
    end
  end
  assign miso_oe_n_o = oe_n_q;
  assign sclk_o = sclk_q;
  assign cs_n_o = cs_q;

endmodule // sfc_top
`default_nettype wire

// *** sfc_chk.sv ***
// Port checker for the SPI FIFO controller top module.
`timescale 1ns/1ps
`default_nettype none
module sfc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sfc_pkg::sfc_wb_req_t wb_i,
  input wire sfc_pkg::sfc_wb_rsp_t wb_o,
  input wire logic irq_o,
  input wire logic sclk_o,
  input wire logic cs_n_o,
  input wire logic cs_n_i,
  input wire logic miso_oe_n_o
);
  import sfc_pkg::*;
  // ==========
  // Shadow copies of the divider and DMA enable, taken at the accepting edge.
  logic [5:0] ratio_q;
  logic dma_q;
  logic wr;
  assign wr = wb_i.cyc && wb_i.stb && wb_i.we && !wb_o.ack;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_q <= 6'h00;
      dma_q <= 1'b0;
    end else if (wr && wb_i.sel[0]) begin
      if (wb_i.adr == SFC_RATE_ADR) ratio_q <= wb_i.dat[5:0];
      if (wb_i.adr == SFC_DMA_ADR) dma_q <= wb_i.dat[0];
    end
  end
  // ==========
  // Cycles between serial clock toggles; only gaps inside one frame are judged.
  logic sclk_p_q;
  logic in_q;
  logic tog;
  int gap_q;
  assign tog = sclk_o != sclk_p_q;
  always_ff @(posedge clk_i) begin
    sclk_p_q <= sclk_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || tog) gap_q <= 1;
    else if (gap_q < 1000) gap_q <= gap_q + 1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n_o) in_q <= 1'b0;
    else if (tog) in_q <= 1'b1;
  end
  // ==========
  // Properties; all of them sleep while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_shot_a: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack stood longer than one cycle");
  ack_on_time_a: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
    else $error("ack missing one cycle after request");
  ack_has_cause_a: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without a request");
  rdata_idle_zero_a: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
    else $error("read data not zero outside ack");
  rx_upper_zero_a: assert property (
    wb_o.ack && !dma_q && $past(wb_i.adr) == SFC_RXB_ADR && !$past(wb_i.we)
    |-> wb_o.dat[31:8] == 24'h0) else $error("receive upper byte not zero");
  sclk_still_idle_a: assert property (cs_n_o && $past(cs_n_o) |-> sclk_o == $past(sclk_o))
    else $error("serial clock moved while deselected");
  sclk_half_period_a: assert property (
    tog && in_q && !cs_n_o |-> gap_q % (ratio_q + 1) == 0 && gap_q > ratio_q)
    else $error("serial clock half period wrong");
  miso_release_a: assert property (cs_n_i |=> miso_oe_n_o)
    else $error("slave output driven while deselected");
  reset_quiet_a: assert property ($past(rst_i) |-> cs_n_o && miso_oe_n_o && !irq_o)
    else $error("outputs not idle after reset");
endmodule // sfc_chk
`default_nettype wire

// *** sfc_spi_dev.sv ***
// Behavioural SPI slave device standing on the controller's serial side.
`timescale 1ns/1ps
`default_nettype none
module sfc_spi_dev (
  input wire logic clk_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // Bytes received, and the answer byte, which steps by one per byte.
  logic [7:0] got_q[$];
  logic [7:0] reply_q = 8'hA5;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  int n = 0;
  logic sclk_p = 1'b0;
  logic cs_p = 1'b1;
  initial miso_o = 1'b0;
  // ==========
  // Mode 0, MSB first: sample on the rising edge, shift on the falling edge.
  always @(posedge clk_i) begin
    if (cs_n_i) begin
      // Released line toggles, so a stale bit never passes for data.
      miso_o <= ~miso_o;
      n = 0;
    end else if (cs_p) begin
      tx = reply_q;
      n = 0;
      miso_o <= tx[7];
    end else if (sclk_i && !sclk_p) begin
      rx = {rx[6:0], mosi_i};
      n++;
      if (n == 8) begin
        got_q.push_back(rx);
        reply_q++;
      end
    end else if (!sclk_i && sclk_p) begin
      // A finished byte reloads at once, as bytes streamed under one held select need.
      if (n == 8) begin
        tx = reply_q;
        n = 0;
      end else tx = tx << 1;
      miso_o <= tx[7];
    end
    sclk_p <= sclk_i;
    cs_p <= cs_n_i;
  end
endmodule // sfc_spi_dev
`default_nettype wire

// *** test_spi_fifo_controller.sv ***
// Self-checking bench: master transfers, loopback, DMA pairs and purges.
`timescale 1ns/1ps
`default_nettype none
module test_spi_fifo_controller;
  import sfc_pkg::*;
  // ==========
  // Setup register values.
  localparam logic [31:0] GO = 32'h3;
  localparam logic [31:0] TRIG = 32'h1 << SFC_S_TRIG;
  localparam logic [31:0] ZERO = 32'h1 << SFC_S_ZERO;
  localparam logic [31:0] LOOP = 32'h1 << SFC_S_LOOP;
  localparam logic [31:0] STRM = 32'h1 << SFC_S_STRM;
  localparam logic [31:0] PRG = 32'h3 << SFC_S_RPRG;
  // Status after a streamed frame with select edge flags on.
  localparam logic [31:0] FLAGS = (32'h3 << SFC_T_FALL) | (32'h1 << SFC_T_TXF) | (32'h1 << SFC_T_IRQ);
  logic clk = 1'b0;
  logic rst = 1'b1;
  sfc_wb_req_t req = '0;
  sfc_wb_rsp_t rsp;
  logic sclk, cs_n, mosi, miso, cs_p;
  logic s_clk = 1'b0, s_cs = 1'b1, s_di = 1'b0, s_do;
  logic [7:0] sq;
  int n_errors = 0;
  int compares = 0;
  int falls = 0;
  logic [31:0] rd;
  logic [7:0] b [6];
  logic [5:0] ratio;
  always #25 clk = ~clk;
  sfc_top #(.DEPTH(4)) DUT (.clk_i(clk), .rst_i(rst), .wb_i(req), .wb_o(rsp), .irq_o(),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .returned_serial_clock_i(sclk), .sclk_i(s_clk), .cs_n_i(s_cs), .mosi_i(s_di),
    .miso_o(s_do), .miso_oe_n_o());
  sfc_spi_dev u_dev (.clk_i(clk), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso));
  // Counts select falls, so a held select shows up as one frame.
  always @(posedge clk) begin
    cs_p <= cs_n;
    if (cs_p === 1'b1 && cs_n === 1'b0) falls <= falls + 1;
  end
  // ==========
  // Expectation, reporting and bus tasks.
  function automatic logic [31:0] reply(input int i);
    return 32'(8'hA5 + 8'(i));
  endfunction
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("unexpected at %0t ns: %s timed out", $time, what);
    end_sim();
  endtask
  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    @(posedge clk);
    while (rsp.ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) hang("bus cycle");
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask
  // Drives k bits of v as a mode 0 master would; the slave's data is taken at each rise.
  task automatic sbits(input logic [7:0] v, input int k);
    for (int i = 0; i < k; i++) begin
      s_di <= v[7 - i];
      repeat (2) @(posedge clk);
      s_clk <= 1'b1;
      sq = {sq[6:0], s_do};
      repeat (2) @(posedge clk);
      s_clk <= 1'b0;
    end
  endtask
  // Waits until the device has taken n bytes and the select is back high.
  task automatic wait_bytes(input int n);
    int t;
    t = 0;
    while ((u_dev.got_q.size() < n || cs_n !== 1'b1) && t < 20000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 20000) hang("serial transfer");
    repeat (4) @(posedge clk);
  endtask
  // ==========
  // Main sequence.
  initial begin
    void'($urandom(32'hABE6C0CF));
    foreach (b[i]) b[i] = 8'($urandom());
    b[0] = 8'h80;
    ratio = 6'($urandom_range(3, 1));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, SFC_SETUP_ADR, 32'h0, 4'hF);
    check(rd, 32'h0, "setup reset");
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, 32'h0, "receive reset");
    wb(1'b0, 32'h4002C020, 32'h0, 4'hF);
    check(rd, 32'h0, "unmapped read");
    wb(1'b1, SFC_RATE_ADR, 32'(ratio) | 32'h1C0, 4'hF);
    wb(1'b0, SFC_RATE_ADR, 32'h0, 4'hF);
    check(rd, 32'(ratio) | 32'h1C0, "rate readback");
    $display("test registers done");
    wb(1'b1, SFC_SETUP_ADR, GO | TRIG | STRM, 4'hF);
    wb(1'b1, SFC_TXB_ADR, 32'(b[0]), 4'hF);
    wb(1'b1, SFC_TXB_ADR, 32'(b[1]), 4'hF);
    wait_bytes(2);
    check(32'(u_dev.got_q[0]), 32'(b[0]), "stream byte 0");
    check(32'(u_dev.got_q[1]), 32'(b[1]), "stream byte 1");
    check(32'(falls), 32'h1, "one frame");
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, reply(0), "receive 0");
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, reply(1), "receive 1");
    wb(1'b0, SFC_STAT_ADR, 32'h0, 4'hF);
    check(rd, FLAGS, "select flags");
    $display("test streaming done");
    wb(1'b1, SFC_SETUP_ADR, GO | TRIG | LOOP, 4'hF);
    wb(1'b1, SFC_TXB_ADR, 32'(b[2]), 4'hF);
    wait_bytes(3);
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, 32'(b[2]), "loopback");
    check(32'(falls), 32'h2, "single frame");
    $display("test loopback done");
    wb(1'b1, SFC_DMA_ADR, 32'h1, 4'hF);
    wb(1'b1, SFC_SETUP_ADR, GO | TRIG | STRM, 4'hF);
    wb(1'b1, SFC_TXB_ADR, {16'h0, b[4], b[3]}, 4'h3);
    wait_bytes(5);
    check(32'(u_dev.got_q[3]), 32'(b[3]), "pair low");
    check(32'(u_dev.got_q[4]), 32'(b[4]), "pair high");
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'h3);
    check(rd, {16'h0, 8'(reply(4)), 8'(reply(3))}, "pair read");
    wb(1'b1, SFC_DMA_ADR, 32'h0, 4'hF);
    $display("test half-word done");
    wb(1'b1, SFC_SETUP_ADR, GO | ZERO | PRG, 4'hF);
    wb(1'b1, SFC_TXB_ADR, 32'hFF, 4'hF);
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, 32'h0, "empty receive");
    wait_bytes(6);
    check(32'(u_dev.got_q[5]), 32'h0, "purge zero fill");
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, 32'h0, "discarded byte");
    wait_bytes(7);
    check(32'(u_dev.got_q[6]), 32'h0, "read starts transfer");
    wb(1'b1, SFC_SETUP_ADR, 32'h0, 4'hF);
    $display("test purge done");
    wb(1'b1, SFC_SETUP_ADR, 32'h1, 4'hF);
    wb(1'b1, SFC_TXB_ADR, 32'(b[5]), 4'hF);
    s_cs <= 1'b0;
    sbits(b[5], 4);
    s_cs <= 1'b1;
    @(posedge clk);
    s_cs <= 1'b0;
    sbits(b[5], 8);
    s_cs <= 1'b1;
    check(32'(sq), 32'(b[5]), "slave resend");
    repeat (2) @(posedge clk);
    wb(1'b0, SFC_RXB_ADR, 32'h0, 4'hF);
    check(rd, 32'(b[5]), "slave receive");
    wb(1'b0, SFC_STAT_ADR, 32'h0, 4'hF);
    check(32'(rd[SFC_T_ABORT]), 32'h1, "abort flag");
    wb(1'b1, SFC_SETUP_ADR, 32'h0, 4'hF);
    $display("test slave done");
    end_sim();
  end
endmodule // test_spi_fifo_controller
bind sfc_top sfc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
  .irq_o(irq_o), .sclk_o(sclk_o), .cs_n_o(cs_n_o), .cs_n_i(cs_n_i),
  .miso_oe_n_o(miso_oe_n_o));
`default_nettype wire
